// [iolc_map.svh]
/*
  Register offsets and reset values of the I/O line configuration
  and interrupt block.
  Assumes inclusion by bare name from any file that needs these numbers.
*/
`ifndef IOLC_MAP_SVH
`define IOLC_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IOLC_OFS_IRQ_ENABLE 8'h00
`define IOLC_OFS_IRQ_DISABLE 8'h04
`define IOLC_OFS_IRQ_MASK 8'h08
`define IOLC_OFS_IRQ_STATUS 8'h0c
`define IOLC_OFS_OD_ENABLE 8'h10
`define IOLC_OFS_OD_DISABLE 8'h14
`define IOLC_OFS_OD_STATUS 8'h18
`define IOLC_OFS_PU_DISABLE 8'h20
`define IOLC_OFS_PU_ENABLE 8'h24
`define IOLC_OFS_PU_STATUS 8'h28
`define IOLC_OFS_PERIPH_A 8'h30
`define IOLC_OFS_PERIPH_B 8'h34
`define IOLC_OFS_PERIPH_STATUS 8'h38
`define IOLC_OFS_DW_ENABLE 8'h40
`define IOLC_OFS_DW_DISABLE 8'h44
`define IOLC_OFS_DW_STATUS 8'h48
`define IOLC_OFS_OUT_LEVEL 8'h50

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IOLC_RST_IRQ_MASK 32'h0000_0000
`define IOLC_RST_IRQ_STATUS 32'h0000_0000
`define IOLC_RST_OD 32'h0000_0000
`define IOLC_RST_PU_OFF 32'h0000_0000
`define IOLC_RST_PERIPH 32'h0000_0000
`define IOLC_RST_DW 32'h0000_0000
`define IOLC_RST_OUT_LEVEL 32'h0000_0000

`endif

// [iolc_pkg.sv]
/*
  Types shared by the I/O line configuration block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package iolc_pkg;

  typedef logic [31:0] iolc_word_t;

  // Register decode result
  typedef enum logic [4:0] {
    IOLC_R_NONE = 5'h00,
    IOLC_R_IRQ_EN = 5'h01,
    IOLC_R_IRQ_DIS = 5'h02,
    IOLC_R_IRQ_MASK = 5'h03,
    IOLC_R_IRQ_STAT = 5'h04,
    IOLC_R_OD_EN = 5'h05,
    IOLC_R_OD_DIS = 5'h06,
    IOLC_R_OD_STAT = 5'h07,
    IOLC_R_PU_DIS = 5'h08,
    IOLC_R_PU_EN = 5'h09,
    IOLC_R_PU_STAT = 5'h0a,
    IOLC_R_PA = 5'h0b,
    IOLC_R_PB = 5'h0c,
    IOLC_R_P_STAT = 5'h0d,
    IOLC_R_DW_EN = 5'h0e,
    IOLC_R_DW_DIS = 5'h0f,
    IOLC_R_DW_STAT = 5'h10,
    IOLC_R_OUT_LVL = 5'h11
  } iolc_reg_t;

endpackage : iolc_pkg

// [iolc_top.sv]
/*
  Per-line configuration and input change interrupt block of a 32-line
  parallel I/O controller: interrupt enable/mask/status, open-drain,
  pull-up, peripheral A/B selection and direct output write gating.
  Assumes a simple register port with one-cycle strobes, read data one
  cycle later, and pin levels already synchronous to i_mclk.
*/
`timescale 1ns/100ps
`include "iolc_map.svh"

module iolc_top #(
  parameter int LINES = 32
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [LINES-1:0] i_pin_level,
  input wire logic [LINES-1:0] i_pio_owns,
  output logic [LINES-1:0] o_pad_out,
  output logic [LINES-1:0] o_pad_oe,
  output logic [LINES-1:0] o_pullup_on,
  output logic [LINES-1:0] o_periph_b_sel,
  output logic o_irq
);

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  function automatic iolc_pkg::iolc_reg_t decode(input logic [7:0] a);
    case (a)
      `IOLC_OFS_IRQ_ENABLE: decode = iolc_pkg::IOLC_R_IRQ_EN;
      `IOLC_OFS_IRQ_DISABLE: decode = iolc_pkg::IOLC_R_IRQ_DIS;
      `IOLC_OFS_IRQ_MASK: decode = iolc_pkg::IOLC_R_IRQ_MASK;
      `IOLC_OFS_IRQ_STATUS: decode = iolc_pkg::IOLC_R_IRQ_STAT;
      `IOLC_OFS_OD_ENABLE: decode = iolc_pkg::IOLC_R_OD_EN;
      `IOLC_OFS_OD_DISABLE: decode = iolc_pkg::IOLC_R_OD_DIS;
      `IOLC_OFS_OD_STATUS: decode = iolc_pkg::IOLC_R_OD_STAT;
      `IOLC_OFS_PU_DISABLE: decode = iolc_pkg::IOLC_R_PU_DIS;
      `IOLC_OFS_PU_ENABLE: decode = iolc_pkg::IOLC_R_PU_EN;
      `IOLC_OFS_PU_STATUS: decode = iolc_pkg::IOLC_R_PU_STAT;
      `IOLC_OFS_PERIPH_A: decode = iolc_pkg::IOLC_R_PA;
      `IOLC_OFS_PERIPH_B: decode = iolc_pkg::IOLC_R_PB;
      `IOLC_OFS_PERIPH_STATUS: decode = iolc_pkg::IOLC_R_P_STAT;
      `IOLC_OFS_DW_ENABLE: decode = iolc_pkg::IOLC_R_DW_EN;
      `IOLC_OFS_DW_DISABLE: decode = iolc_pkg::IOLC_R_DW_DIS;
      `IOLC_OFS_DW_STATUS: decode = iolc_pkg::IOLC_R_DW_STAT;
      `IOLC_OFS_OUT_LEVEL: decode = iolc_pkg::IOLC_R_OUT_LVL;
      default: decode = iolc_pkg::IOLC_R_NONE;
    endcase
  endfunction : decode

  // Set/clear pair: set bits from one write, clear bits from another
  function automatic logic [LINES-1:0] set_clr(input logic [LINES-1:0] cur,
      input logic [LINES-1:0] s, input logic [LINES-1:0] c);
    set_clr = (cur | s) & ~c;
  endfunction : set_clr

  iolc_pkg::iolc_reg_t sel;
  assign sel = decode(i_addr);

  wire [LINES-1:0] wd = i_wdata[LINES-1:0];
  wire [LINES-1:0] zero = '0;

  function automatic logic [LINES-1:0] wsel(input logic hit,
      input logic [LINES-1:0] d);
    wsel = hit ? d : '0;
  endfunction : wsel

  wire w_irq_en = i_wr && sel == iolc_pkg::IOLC_R_IRQ_EN;
  wire w_irq_dis = i_wr && sel == iolc_pkg::IOLC_R_IRQ_DIS;
  wire w_od_en = i_wr && sel == iolc_pkg::IOLC_R_OD_EN;
  wire w_od_dis = i_wr && sel == iolc_pkg::IOLC_R_OD_DIS;
  wire w_pu_dis = i_wr && sel == iolc_pkg::IOLC_R_PU_DIS;
  wire w_pu_en = i_wr && sel == iolc_pkg::IOLC_R_PU_EN;
  wire w_pa = i_wr && sel == iolc_pkg::IOLC_R_PA;
  wire w_pb = i_wr && sel == iolc_pkg::IOLC_R_PB;
  wire w_dw_en = i_wr && sel == iolc_pkg::IOLC_R_DW_EN;
  wire w_dw_dis = i_wr && sel == iolc_pkg::IOLC_R_DW_DIS;
  wire w_out = i_wr && sel == iolc_pkg::IOLC_R_OUT_LVL;
  wire r_stat = i_rd && sel == iolc_pkg::IOLC_R_IRQ_STAT;

  // --------------------------------------------------------------------
  // Per-line state
  // --------------------------------------------------------------------
  logic [LINES-1:0] mask_ff, stat_ff, od_ff, pu_off_ff, pb_ff, dw_ff;
  logic [LINES-1:0] lvl_ff, pin_prev_ff, out_ff, pullup_on_ff;
  logic pin_valid_ff;
  logic [31:0] rdata_ff;
  logic irq_ff;

  wire [LINES-1:0] nxt_mask =
    set_clr(mask_ff, wsel(w_irq_en, wd), wsel(w_irq_dis, wd));
  wire [LINES-1:0] nxt_od =
    set_clr(od_ff, wsel(w_od_en, wd), wsel(w_od_dis, wd));
  wire [LINES-1:0] nxt_pu_off =
    set_clr(pu_off_ff, wsel(w_pu_dis, wd), wsel(w_pu_en, wd));
  wire [LINES-1:0] nxt_pb =
    set_clr(pb_ff, wsel(w_pb, wd), wsel(w_pa, wd));
  wire [LINES-1:0] nxt_dw =
    set_clr(dw_ff, wsel(w_dw_en, wd), wsel(w_dw_dis, wd));
  // every pair above is a plain set/clear of one state bit

  // Output level: direct write only touches lines whose gate is open
  wire [LINES-1:0] nxt_lvl = w_out ?
    ((lvl_ff & ~dw_ff) | (wd & dw_ff)) : lvl_ff;

  // Change detection; the first sample after reset has no reference
  wire [LINES-1:0] chg = pin_valid_ff ? (i_pin_level ^ pin_prev_ff) : zero;
  // A change seen in the read cycle survives the clear
  wire [LINES-1:0] nxt_stat = (r_stat ? zero : stat_ff) | chg;
  wire nxt_irq = |(nxt_stat & nxt_mask);

  // Open drain: drive only when the level is low
  wire [LINES-1:0] nxt_oe = i_pio_owns & (~nxt_od | ~nxt_lvl);

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    case (sel)
      iolc_pkg::IOLC_R_IRQ_MASK: rmux[LINES-1:0] = mask_ff;
      iolc_pkg::IOLC_R_IRQ_STAT: rmux[LINES-1:0] = stat_ff;
      iolc_pkg::IOLC_R_OD_STAT: rmux[LINES-1:0] = od_ff;
      iolc_pkg::IOLC_R_PU_STAT: rmux[LINES-1:0] = pu_off_ff;
      iolc_pkg::IOLC_R_P_STAT: rmux[LINES-1:0] = pb_ff;
      iolc_pkg::IOLC_R_DW_STAT: rmux[LINES-1:0] = dw_ff;
      iolc_pkg::IOLC_R_OUT_LVL: rmux[LINES-1:0] = lvl_ff;
      default: rmux = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      mask_ff <= LINES'(`IOLC_RST_IRQ_MASK);
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      stat_ff <= LINES'(`IOLC_RST_IRQ_STATUS);
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      od_ff <= LINES'(`IOLC_RST_OD);
    end else begin
      od_ff <= nxt_od;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pu_off_ff <= LINES'(`IOLC_RST_PU_OFF);
    end else begin
      pu_off_ff <= nxt_pu_off;
    end
  end

  // Own flop so the pad control pin never sees an inverter glitch
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pullup_on_ff <= ~LINES'(`IOLC_RST_PU_OFF);
    end else begin
      pullup_on_ff <= ~nxt_pu_off;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pb_ff <= LINES'(`IOLC_RST_PERIPH);
    end else begin
      pb_ff <= nxt_pb;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      dw_ff <= LINES'(`IOLC_RST_DW);
    end else begin
      dw_ff <= nxt_dw;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      lvl_ff <= LINES'(`IOLC_RST_OUT_LEVEL);
    end else begin
      lvl_ff <= nxt_lvl;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pin_prev_ff <= '0;
      pin_valid_ff <= 1'b0;
    end else begin
      pin_prev_ff <= i_pin_level;
      pin_valid_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      out_ff <= '0;
    end else begin
      out_ff <= nxt_oe;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= i_rd ? rmux : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  logic [LINES-1:0] pad_lvl_ff;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pad_lvl_ff <= '0;
    end else begin
      pad_lvl_ff <= nxt_lvl;
    end
  end

  // --------------------------------------------------------------------
  // Output drivers
  // --------------------------------------------------------------------
  assign o_rdata = rdata_ff;
  assign o_pad_out = pad_lvl_ff;
  assign o_pad_oe = out_ff;
  assign o_pullup_on = pullup_on_ff;
  assign o_periph_b_sel = pb_ff;
  assign o_irq = irq_ff;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  a_irq_enable_sets: assert property (
    w_irq_en |=> ((mask_ff & $past(wd)) == $past(wd)))
    else $error("enable write did not set mask");
  a_irq_disable_clr: assert property (
    w_irq_dis |=> ((mask_ff & $past(wd)) == '0))
    else $error("disable write did not clear mask");
  a_mask_read_back: assert property (
    i_rd && sel == iolc_pkg::IOLC_R_IRQ_MASK
      |=> o_rdata[LINES-1:0] == $past(mask_ff))
    else $error("mask read wrong");
  a_status_read_clr: assert property (
    r_stat && chg == '0 ##1 chg == '0 |=> stat_ff == '0)
    else $error("status not cleared by read");
  a_change_sets_stat: assert property (
    chg != '0 |=> (stat_ff & $past(chg)) == $past(chg))
    else $error("change did not set status");
  a_od_drive_low: assert property (
    |(o_pad_oe & od_ff & o_pad_out) == 1'b0)
    else $error("open drain line drives high");
  a_pullup_polar: assert property (
    w_pu_en |=> ##1 (o_pullup_on & $past(wd, 2)) == $past(wd, 2))
    else $error("pullup enable not active");
  a_periph_select: assert property (
    w_pb && !w_pa |=> ((pb_ff & $past(wd)) == $past(wd)))
    else $error("periph B not selected");
  a_dw_gate: assert property (
    w_out |=> ((lvl_ff ^ $past(lvl_ff)) & ~$past(dw_ff)) == '0)
    else $error("gated line changed by direct write");
  a_irq_level: assert property (
    ##1 o_irq == |($past(nxt_stat) & $past(nxt_mask)))
    else $error("interrupt output wrong");
  a_od_enable_sets: assert property (
    w_od_en |=> ((od_ff & $past(wd)) == $past(wd)))
    else $error("open drain enable did not set");
  a_od_disable_clr: assert property (
    w_od_dis |=> ((od_ff & $past(wd)) == '0))
    else $error("open drain disable did not clear");
  a_pp_drive_both: assert property (
    ##1 (((o_pad_oe ^ $past(i_pio_owns)) & ~od_ff) == '0))
    else $error("push-pull line enable wrong");
  a_pu_disable_sets: assert property (
    w_pu_dis |=> ((pu_off_ff & $past(wd)) == $past(wd)))
    else $error("pullup disable did not set");
  a_pu_enable_clr: assert property (
    w_pu_en |=> ((pu_off_ff & $past(wd)) == '0))
    else $error("pullup enable did not clear");
  a_pu_status_read: assert property (
    i_rd && sel == iolc_pkg::IOLC_R_PU_STAT
      |=> o_rdata[LINES-1:0] == ~$past(o_pullup_on))
    else $error("pullup status polarity wrong");
  a_pa_select: assert property (
    w_pa |=> ((pb_ff & $past(wd)) == '0))
    else $error("periph A not selected");
  a_periph_read: assert property (
    i_rd && sel == iolc_pkg::IOLC_R_P_STAT
      |=> o_rdata[LINES-1:0] == $past(o_periph_b_sel))
    else $error("periph status read wrong");
  a_dw_enable_sets: assert property (
    w_dw_en |=> ((dw_ff & $past(wd)) == $past(wd)))
    else $error("direct write enable did not set");
  a_dw_disable_clr: assert property (
    w_dw_dis |=> ((dw_ff & $past(wd)) == '0))
    else $error("direct write disable did not clear");
  a_dw_write_lands: assert property (
    w_out |=> (((lvl_ff ^ $past(wd)) & $past(dw_ff)) == '0))
    else $error("open line missed direct write");
  a_level_read: assert property (
    i_rd && sel == iolc_pkg::IOLC_R_OUT_LVL
      |=> o_rdata[LINES-1:0] == $past(o_pad_out))
    else $error("output level read wrong");
  a_cfg_hold_a: assert property (
    !i_wr |=> $stable(mask_ff) && $stable(od_ff) && $stable(pu_off_ff))
    else $error("state changed without write");
  a_cfg_hold_b: assert property (
    !i_wr |=> $stable(pb_ff) && $stable(dw_ff) && $stable(lvl_ff))
    else $error("state changed without write");
  a_stat_hold: assert property (
    !r_stat |=> (($past(stat_ff) & ~stat_ff) == '0))
    else $error("status fell without read");
  a_irq_status_read: assert property (
    r_stat |=> o_rdata[LINES-1:0] == $past(stat_ff))
    else $error("status read returned wrong value");
  a_irq_follows: assert property (
    o_irq == |(stat_ff & mask_ff))
    else $error("interrupt not status and mask");

  // --------------------------------------------------------------------
  // Cover points
  // --------------------------------------------------------------------

  c_irq_fire: cover property (w_irq_en ##[1:20] o_irq);
  c_status_clear: cover property (o_irq ##1 r_stat ##2 !o_irq);
  c_od_line: cover property (w_od_en ##[1:10] |(o_pad_oe & od_ff));
  c_dw_write: cover property (w_dw_en ##[1:10] w_out);
  c_pull_off: cover property (w_pu_dis ##1 o_pullup_on != '1);

endmodule : iolc_top

// [iolc_pad_model.sv]
/*
  Behavioural model of the 32 pads and the board around them.
  Assumes the design drives pad level and enable registered on i_mclk.
*/
`timescale 1ns/100ps

module iolc_pad_model (
  input wire logic i_mclk,
  input wire logic [31:0] i_pad_out,
  input wire logic [31:0] i_pad_oe,
  input wire logic [31:0] i_pullup_on,
  input wire logic [31:0] i_ext_en,
  input wire logic [31:0] i_ext_val,
  output logic [31:0] o_level
);
  logic [31:0] last_ff = 32'h0000_0000;
  wire [31:0] driven = i_pad_oe | i_ext_en;
  // Wired-AND: an enabled low wins over any high
  wire [31:0] drv_lvl = (~i_pad_oe | i_pad_out) & (~i_ext_en | i_ext_val);
  // A floating line without pull-up flips each cycle, never holds
  assign o_level = (driven & drv_lvl) | (~driven & i_pullup_on) |
                   (~driven & ~i_pullup_on & ~last_ff);
  always_ff @(posedge i_mclk) begin
    last_ff <= o_level;
  end
endmodule : iolc_pad_model

// [iolc_top_tb.sv]
/*
  Self-checking bench of the line configuration and interrupt block.
  Assumes iolc_map.svh offsets and the pad model beside the design.
*/
`timescale 1ns/100ps
`include "iolc_map.svh"

module iolc_top_tb;
  logic i_mclk = 1'b0;
  logic i_rst_b, i_wr, i_rd, o_irq;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, pin_level, i_pio_owns, o_pad_out, o_pad_oe;
  logic [31:0] o_pullup_on, o_periph_b_sel, ext_en, ext_val, rdata;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  // Set, clear and status offsets of the five triplets
  logic [7:0] set_ofs [5] = '{`IOLC_OFS_IRQ_ENABLE, `IOLC_OFS_OD_ENABLE,
    `IOLC_OFS_PU_DISABLE, `IOLC_OFS_PERIPH_B, `IOLC_OFS_DW_ENABLE};
  logic [7:0] clr_ofs [5] = '{`IOLC_OFS_IRQ_DISABLE, `IOLC_OFS_OD_DISABLE,
    `IOLC_OFS_PU_ENABLE, `IOLC_OFS_PERIPH_A, `IOLC_OFS_DW_DISABLE};
  logic [7:0] st_ofs [5] = '{`IOLC_OFS_IRQ_MASK, `IOLC_OFS_OD_STATUS,
    `IOLC_OFS_PU_STATUS, `IOLC_OFS_PERIPH_STATUS, `IOLC_OFS_DW_STATUS};

  always #50 i_mclk = ~i_mclk;

  iolc_top i_iolc_top (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pin_level(pin_level), .i_pio_owns(i_pio_owns), .o_pad_out(o_pad_out),
    .o_pad_oe(o_pad_oe), .o_pullup_on(o_pullup_on),
    .o_periph_b_sel(o_periph_b_sel), .o_irq(o_irq));

  iolc_pad_model i_iolc_pad_model (.i_mclk(i_mclk), .i_pad_out(o_pad_out),
    .i_pad_oe(o_pad_oe), .i_pullup_on(o_pullup_on), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_level(pin_level));

  // ----------------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe is taken
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    rdata = o_rdata;
    chk(rdata, exp);
  endtask : rdchk

  task automatic end_sim();
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // Whole run needs well under 1000 cycles
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    i_rst_b = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    // Peripheral owns every line first: pins follow only the outside drive
    i_pio_owns = 32'h0000_0000;
    ext_en = 32'hffff_ffff;
    ext_val = 32'hffff_ffff;
    repeat (12) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      rdchk(st_ofs[k], 32'h0000_0000);
    end
    rdchk(`IOLC_OFS_IRQ_STATUS, 32'h0000_0000);
    rdchk(8'h5c, 32'h0000_0000);
    chk(o_pullup_on, 32'hffff_ffff);
    // Set, no-op set, ignored status write, clear, no-op clear
    for (int k = 0; k < 5; k++) begin
      wr(set_ofs[k], 32'ha5a5_0f0f);
      wr(set_ofs[k], 32'h0000_0000);
      rdchk(st_ofs[k], 32'ha5a5_0f0f);
      wr(st_ofs[k], 32'hffff_ffff);
      wr(clr_ofs[k], 32'h0000_0f00);
      wr(clr_ofs[k], 32'h0000_0000);
      rdchk(st_ofs[k], 32'ha5a5_000f);
      if (k == 2) chk(o_pullup_on, 32'h5a5a_fff0);
      if (k == 3) chk(o_periph_b_sel, 32'ha5a5_000f);
      wr(clr_ofs[k], 32'hffff_ffff);
      rdchk(st_ofs[k], 32'h0000_0000);
    end
    // Input change on lines 1 and 5, only line 1 unmasked
    wr(`IOLC_OFS_IRQ_ENABLE, 32'h0000_0002);
    @(posedge i_mclk);
    ext_val <= 32'hffff_ffdd;
    repeat (3) @(posedge i_mclk);
    #1;
    chk({31'h0, o_irq}, 32'h1);
    rdchk(`IOLC_OFS_IRQ_STATUS, 32'h0000_0022);
    chk({31'h0, o_irq}, 32'h0);
    rdchk(`IOLC_OFS_IRQ_STATUS, 32'h0000_0000);
    wr(`IOLC_OFS_IRQ_DISABLE, 32'h0000_0002);
    @(posedge i_mclk);
    ext_val <= 32'hffff_ffff;
    repeat (3) @(posedge i_mclk);
    #1;
    chk({31'h0, o_irq}, 32'h0);
    rdchk(`IOLC_OFS_IRQ_STATUS, 32'h0000_0022);
    // Gated direct output writes and open-drain drive
    @(posedge i_mclk);
    i_pio_owns <= 32'hffff_ffff;
    wr(`IOLC_OFS_OD_ENABLE, 32'h0000_0003);
    wr(`IOLC_OFS_DW_ENABLE, 32'h0000_000f);
    wr(`IOLC_OFS_OUT_LEVEL, 32'hffff_ff05);
    rdchk(`IOLC_OFS_OUT_LEVEL, 32'h0000_0005);
    chk(o_pad_out, 32'h0000_0005);
    chk(o_pad_oe, 32'hffff_fffe);
    @(posedge i_mclk);
    i_pio_owns <= 32'hffff_0000;
    @(posedge i_mclk);
    #1;
    chk(o_pad_oe, 32'hffff_0000);
    wr(`IOLC_OFS_DW_DISABLE, 32'h0000_0001);
    wr(`IOLC_OFS_OUT_LEVEL, 32'h0000_0000);
    rdchk(`IOLC_OFS_OUT_LEVEL, 32'h0000_0001);
    rdchk(`IOLC_OFS_DW_STATUS, 32'h0000_000e);
    end_sim();
  end
endmodule : iolc_top_tb
